// file: core/rrs_cfg.svh
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH
// instruction word layout (14-bit)
`define RRS_OP_RETURN 14'h0008
`define RRS_OP_SLEEP 14'h0063
`define RRS_ROT_MASK 14'h3F00
`define RRS_ROT_LEFT 14'h0D00
`define RRS_ROT_RIGHT 14'h0C00
`define RRS_DEST_BIT 7
`define RRS_WDT_CLEAR 8'h00
`define RRS_PC_RESET 15'h0000
`define RRS_RET_CYCLES 2
`endif

// file: core/rrs_pkg.sv
package rrs_pkg;
  // execution sequencer states, gray along run -> flush
  typedef enum logic [1:0] {
    st_run_t = 2'b00,
    st_flush_t = 2'b01,
    st_sleep_t = 2'b11
  } exec_state_t;
endpackage

// file: core/rotate_unit.sv
`timescale 1ns/1ps
// combinational rotate through carry
module rotate_unit (
  // operands
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic dir_left,
  // results
  output logic [7:0] result,
  output logic carry_out
);
  // left: msb to carry, carry to bit 0
  wire [7:0] left_val = {operand[6:0], carry_in};
  // right: lsb to carry, carry to bit 7
  wire [7:0] right_val = {carry_in, operand[7:1]};
  assign result = dir_left ? left_val : right_val;
  assign carry_out = dir_left ? operand[7] : operand[0];
endmodule

// file: core/rotate_return_sleep_exec.sv
`timescale 1ns/1ps
`include "rrs_cfg.svh"
// What this block does
// - return pops stack, loads program counter
// - return takes two cycles, fetch discarded
// - rotate left: bit7 to carry, carry in
// - rotate right: bit0 to carry, carry in
// - dest 0 writes W, 1 writes file
// - sleep clears active-low powerdown flag
// - sleep sets active-low timeout flag
// - sleep clears watchdog and prescaler, sleeps
module rotate_return_sleep_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // decoded instruction from fetch
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  // wake from sleep request, same clock
  input wire logic wake_req,
  // operand sources
  input wire logic [7:0] file_rd_data,
  input wire logic [14:0] stack_top_value,
  input wire logic carry_in,
  // program counter and stack
  output logic pc_load,
  output logic [14:0] pc_value,
  output logic stack_pop,
  output logic fetch_flush,
  // results
  output logic w_we,
  output logic [7:0] w_data,
  output logic file_we,
  output logic [7:0] file_wr_data,
  output logic carry_we,
  output logic carry_out,
  // power state
  output logic watchdog_clear,
  output logic prescaler_clear,
  output logic powerdown_flag_n,
  output logic timeout_flag_n,
  output logic sleeping
);
  // reset synchroniser: stage one feeds only stage two
  // assertion is asynchronous so outputs drop at once,
  // but release is retimed to clk to avoid a recovery
  // hazard on the flops below; the cost is two dead
  // cycles after rst_b rises before anything is taken
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n_int = rst_s2_reg;
  // every other process resets from this copy only;
  // the raw pin is never read past the synchroniser

  // opcode class match, shared by both rotate decodes
  // the low byte holds file address and destination,
  // so only the class bits take part in the compare
  function automatic logic op_class(input logic [13:0] word, input logic [13:0] pattern);
    op_class = ((word & `RRS_ROT_MASK) == pattern);
  endfunction

  // sequencer state
  rrs_pkg::exec_state_t state_reg;
  rrs_pkg::exec_state_t state_next;

  // decode, only while running so flushed fetch is ignored
  // go is the single gate for all four instructions:
  // the slot after a return and the whole sleep span
  // are dropped here, so no writer below needs its own
  // check of the sequencer state
  // no port reports a dropped word; fetch must know
  // from fetch_flush and sleeping that it was lost
  wire running = (state_reg == rrs_pkg::st_run_t);
  wire go = instr_valid & running;
  wire is_return = go & (instr_word == `RRS_OP_RETURN);
  wire is_sleep = go & (instr_word == `RRS_OP_SLEEP);
  wire is_rl = go & op_class(instr_word, `RRS_ROT_LEFT);
  wire is_rr = go & op_class(instr_word, `RRS_ROT_RIGHT);
  wire is_rot = is_rl | is_rr;
  wire dest_file = instr_word[`RRS_DEST_BIT];

  // rotate datapath
  // purely combinational, result is registered below
  // direction follows the left decode; when no rotate is
  // decoded the unit still computes a right rotate, which
  // is harmless since no write enable is raised then
  wire [7:0] rot_result;
  wire rot_carry;
  rotate_unit u_rot (
    .operand(file_rd_data),
    .carry_in(carry_in),
    .dir_left(is_rl),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  // next-state: return flushes one cycle, sleep waits for wake
  // run: normal issue, one instruction per cycle
  // flush: the word fetched behind a return is discarded
  // sleep: everything is ignored until wake_req is seen
  // limitation: wake_req is sampled only in sleep, a
  // request raised while running is simply lost
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rrs_pkg::st_run_t: begin
        if (is_return) begin
          state_next = rrs_pkg::st_flush_t;
        end else if (is_sleep) begin
          state_next = rrs_pkg::st_sleep_t;
        end
      end
      rrs_pkg::st_flush_t: begin
        state_next = rrs_pkg::st_run_t;
      end
      rrs_pkg::st_sleep_t: begin
        if (wake_req) begin
          state_next = rrs_pkg::st_run_t;
        end
      end
      default: begin
        state_next = rrs_pkg::st_run_t;
      end
    endcase
  end

  // state register
  // reset lands in run so the first fetch can execute
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= rrs_pkg::st_run_t;
    end else begin
      state_reg <= state_next;
    end
  end

  // return: pop and load pc, and flag fetch discard in the same cycle
  // the three pulses share one cycle so the stack, the
  // pc and the fetch unit all see the return together
  // pc_value is held between returns; pc_load tells the
  // pc when to take it, which keeps this path narrow
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pc_load <= 1'b0;
      pc_value <= `RRS_PC_RESET;
      stack_pop <= 1'b0;
      fetch_flush <= 1'b0;
    end else begin
      pc_load <= is_return;
      stack_pop <= is_return;
      fetch_flush <= is_return;
      if (is_return) begin
        pc_value <= stack_top_value;
      end
    end
  end

  // rotate: single cycle writeback, carry is the only flag
  // both data ports carry the same result; the enables
  // pick the destination, trading a few flops for no mux
  // zero and digit carry have no port at all, so they
  // cannot be disturbed by this block
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      w_we <= 1'b0;
      w_data <= 8'h00;
      file_we <= 1'b0;
      file_wr_data <= 8'h00;
      carry_we <= 1'b0;
      carry_out <= 1'b0;
    end else begin
      w_we <= is_rot & ~dest_file;
      file_we <= is_rot & dest_file;
      carry_we <= is_rot;
      if (is_rot) begin
        w_data <= rot_result;
        file_wr_data <= rot_result;
        carry_out <= rot_carry;
      end
    end
  end

  // sleep: status bits and watchdog clear pulses
  // the clears are one-cycle pulses; the watchdog and its
  // prescaler zero themselves on seeing them
  // sleeping mirrors the sequencer state one to one, so
  // the clock gate outside sees a clean flop output
  // flags hold after wake; other status writers live outside
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      powerdown_flag_n <= 1'b1;
      timeout_flag_n <= 1'b1;
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      watchdog_clear <= is_sleep;
      prescaler_clear <= is_sleep;
      sleeping <= (state_next == rrs_pkg::st_sleep_t);
      if (is_sleep) begin
        powerdown_flag_n <= 1'b0;
        timeout_flag_n <= 1'b1;
      end
    end
  end
endmodule

// file: test/rrs_assertions.sv
`timescale 1ns/1ps
// watches the exec block from its ports only
module rrs_assertions (
  input wire logic clk, rst_b, instr_valid, wake_req, carry_in,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rd_data, w_data, file_wr_data,
  input wire logic [14:0] stack_top_value, pc_value,
  input wire logic pc_load, stack_pop, fetch_flush, w_we, file_we, carry_we, carry_out,
  input wire logic watchdog_clear, prescaler_clear, powerdown_flag_n, timeout_flag_n, sleeping
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // pc_load marks the flush slot, so nothing is taken there
  wire take = instr_valid && !sleeping && !pc_load;
  // whichever destination the rotate picked
  wire [7:0] dst = w_we ? w_data : file_wr_data;
  sequence ret_s; take && instr_word == 14'h0008; endsequence
  sequence rot_s; take && instr_word[13:9] == 5'b00110; endsequence
  sequence slp_s; take && instr_word == 14'h0063; endsequence
  ret_pop_a: assert property (ret_s |=> pc_load && stack_pop && pc_value == $past(stack_top_value))
    else $error("return did not pop");
  ret_flush_a: assert property (ret_s |=> fetch_flush ##1 !pc_load && !carry_we && !w_we && !file_we)
    else $error("return slot not flushed");
  rot_left_a: assert property (rot_s and instr_word[8] |=> {carry_out, dst} == {$past(file_rd_data), $past(carry_in)})
    else $error("left rotate wrong");
  rot_right_a: assert property (rot_s and !instr_word[8] |=> {dst, carry_out} == {$past(carry_in), $past(file_rd_data)})
    else $error("right rotate wrong");
  rot_dest_a: assert property (rot_s |=> w_we == !$past(instr_word[7]) && file_we == $past(instr_word[7]))
    else $error("rotate destination wrong");
  sleep_flags_a: assert property (slp_s |=> !powerdown_flag_n && timeout_flag_n && sleeping)
    else $error("sleep flags wrong");
  sleep_wdt_a: assert property (slp_s |=> watchdog_clear && prescaler_clear)
    else $error("watchdog not cleared");
  rot_once_a: assert property (rot_s ##1 !instr_valid |-> carry_we ##1 !carry_we)
    else $error("rotate not single cycle");
  keep_carry_a: assert property (ret_s or slp_s |=> !carry_we)
    else $error("carry touched");
endmodule
bind rotate_return_sleep_exec rrs_assertions chk (.*);

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, wake_req = 1'b0, carry_in = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rd_data = 8'h00;
  logic [14:0] stack_top_value = 15'h0000;
  logic pc_load, stack_pop, fetch_flush, w_we, file_we, carry_we, carry_out, watchdog_clear;
  logic prescaler_clear, powerdown_flag_n, timeout_flag_n, sleeping;
  logic [14:0] pc_value;
  logic [7:0] w_data, file_wr_data;
  int n_mismatch = 0, checks_done = 0;
  always #20 clk = ~clk;
  rotate_return_sleep_exec dut (.*);
  task check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // one instruction for one cycle, outputs settled on return
  task issue(input logic [13:0] w, input logic [7:0] f, input logic c);
    @(posedge clk);
    instr_valid <= 1'b1; instr_word <= w; file_rd_data <= f; carry_in <= c;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  // all four rotate flavours, both destinations
  task t_rot;
    logic [7:0] f, r;
    logic l, d, c;
    for (int i = 0; i < 4; i++) begin
      d = i[0]; l = i[1]; c = i[0] ^ i[1]; f = 8'hE6 + 8'(i);
      r = l ? {f[6:0], c} : {c, f[7:1]};
      issue({5'b00110, l, d, 7'h2B}, f, c);
      check({carry_we, w_we, file_we, carry_out}, {1'b1, !d, d, l ? f[7] : f[0]});
      check(d ? file_wr_data : w_data, r);
    end
  endtask
  // return with a rotate in the flush slot that must vanish
  task t_ret;
    @(posedge clk);
    instr_valid <= 1'b1; instr_word <= 14'h0008; stack_top_value <= 15'h5A3C;
    @(posedge clk);
    instr_word <= 14'h0D80;
    #1 check({pc_load, stack_pop, fetch_flush, carry_we}, 4'hE);
    check(pc_value, 15'h5A3C);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 check({pc_load, file_we, carry_we}, 3'h0);
  endtask
  // sleep, ignored work while asleep, then wake
  task t_sleep;
    issue(14'h0063, 8'h00, 1'b0);
    check({watchdog_clear, prescaler_clear, powerdown_flag_n, timeout_flag_n, sleeping, carry_we}, 6'h36);
    issue(14'h0D80, 8'h81, 1'b0);
    check({file_we, carry_we, sleeping}, 3'h1);
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    #1 check({sleeping, powerdown_flag_n, timeout_flag_n}, 3'h1);
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run is a few dozen cycles
  initial begin
    #100000 n_mismatch++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({powerdown_flag_n, timeout_flag_n, pc_value}, 17'h18000);
    t_rot;
    t_ret;
    t_sleep;
    results;
  end
endmodule
